// [dv/ddrsa_core_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench
// ********
module ddrsa_core_bench;
    import ddrsa_pkg::*;
    logic             clk_i   = 1'b0;
    logic             rst_b_i = 1'b0;
    logic             cke;
    logic [CMD_W-1:0] cmd_r;
    logic [CMD_W-1:0] cmd_f;
    logic [DQ_W-1:0]  wd_r;
    logic [DQ_W-1:0]  wd_f;
    logic [DQ_W-1:0]  rd_r;
    logic [DQ_W-1:0]  rd_f;
    logic             oe_b;
    logic             rd_valid;
    logic             wr_ready;
    logic             busy;
    logic             cmd_err;
    logic [BANKS-1:0] bank_open;
    logic [7:0]       mem_m [bit [9:0]];
    logic [13:0]      row_m [8];
    logic [2:0]       b;
    logic [9:0]       c;
    int               failures = 0;
    int               checked  = 0;
    int               cyc      = 0;
    always #25 clk_i = ~clk_i;
    ddrsa_core ddrsa_core_i (
        .clk_i, .rst_b_i, .cke_i(cke), .cmd_addr_bus_rise_i(cmd_r), .cmd_addr_bus_fall_i(cmd_f),
        .dq_rise_i(wd_r), .dq_fall_i(wd_f), .dq_rise_o(rd_r), .dq_fall_o(rd_f),
        .dq_oe_b_o(oe_b), .rd_valid_o(rd_valid), .wr_ready_o(wr_ready), .busy_o(busy),
        .cmd_err_o(cmd_err), .bank_open_o(bank_open)
    );
    ddrsa_ctl ddrsa_ctl_i (
        .clk_i, .cke_o(cke), .cmd_rise_o(cmd_r), .cmd_fall_o(cmd_f), .dq_rise_o(wd_r),
        .dq_fall_o(wd_f)
    );
    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [9:0] key(input logic [2:0] bk, input logic [9:0] col, input int j);
        return {bk, row_m[bk][1:0], col[4:3], 3'(col[2:0] + j)};
    endfunction
    function automatic logic [16:0] beats(input logic [2:0] bk, input logic [9:0] col, input int k);
        return {1'b1, mem_m[key(bk, col, 2*k)], mem_m[key(bk, col, 2*k+1)]};
    endfunction
    // NOP, then look at the refusal flag of the command just taken
    task automatic step(input logic e);
        ddrsa_ctl_i.idle();
        #1;
        chk(cmd_err, e);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [2:0] bk, input logic e);
        ddrsa_ctl_i.send(op, bk, row_m[bk], 10'h000);
        step(e);
    endtask
    task automatic wr(input logic [2:0] bk, input logic [9:0] col);
        logic [63:0] w;
        w = {$urandom, $urandom};
        for (int j = 0; j < 8; j++)
            mem_m[key(bk, col, j)] = w[8*j +: 8];
        ddrsa_ctl_i.send(DDRSA_OP_WR, bk, 14'h0000, col);
        ddrsa_ctl_i.wdata(w);
    endtask
    // Poke sends a precharge into the busy window, which must be refused
    task automatic rd(input logic [2:0] bk, input logic [9:0] col, input logic poke);
        int n;
        n = 0;
        ddrsa_ctl_i.send(DDRSA_OP_RD, bk, 14'h0000, col);
        step(1'b0);
        if (poke)
            cmd(DDRSA_OP_PRE, bk, 1'b1);
        while (rd_valid !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        for (int k = 0; k < 4; k++)
        begin
            chk({rd_valid, rd_r, rd_f}, beats(bk, col, k));
            @(posedge clk_i);
            #1;
        end
    endtask
    initial
    begin
        void'($urandom(30079));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk({bank_open, busy, oe_b, rd_valid, wr_ready, cmd_err}, 13'h00A);
        for (int i = 0; i < 8; i++)
        begin
            row_m[i] = 14'($urandom);
            ddrsa_ctl_i.send(DDRSA_OP_ACT, 3'(i), row_m[i], 10'h000);
        end
        step(1'b0);
        chk(bank_open, 8'hFF);
        cmd(DDRSA_OP_ACT, 3'h0, 1'b1);
        for (int op = 5; op < 8; op++)
            cmd(3'(op), 3'h2, 1'b1);
        cmd(DDRSA_OP_PRE, 3'h5, 1'b0);
        cmd(DDRSA_OP_WR, 3'h5, 1'b1);
        ddrsa_ctl_i.hold_cke(1'b0);
        cmd(DDRSA_OP_ACT, 3'h5, 1'b0);
        chk(bank_open, 8'hDF);
        ddrsa_ctl_i.hold_cke(1'b1);
        cmd(DDRSA_OP_ACT, 3'h5, 1'b0);
        $display("test commands done");
        for (int i = 0; i < 40; i++)
        begin
            b = 3'($urandom);
            c = 10'($urandom);
            if (i % 4 == 1)
            begin
                cmd(DDRSA_OP_PRE, b, 1'b0);
                row_m[b] = 14'($urandom);
                cmd(DDRSA_OP_ACT, b, 1'b0);
            end
            wr(b, c);
            if (i % 3 == 0)
                wr(b, c ^ 10'h008);
            rd(b, {c[9:3], 3'($urandom)}, i % 5 == 0);
        end
        $display("test bursts done");
        // Mid-run reset must close every bank and idle the pins
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk({bank_open, busy, oe_b, rd_valid, wr_ready, cmd_err}, 13'h00A);
        cmd(DDRSA_OP_ACT, 3'h3, 1'b0);
        chk(bank_open, 8'h08);
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire

// [dv/ddrsa_core_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checks
// ********
module ddrsa_core_props (
    input wire logic                        clk_i,
    input wire logic                        rst_b_i,
    input wire logic                        cke_i,
    input wire logic [ddrsa_pkg::CMD_W-1:0] cmd_addr_bus_rise_i,
    input wire logic [ddrsa_pkg::DQ_W-1:0]  dq_rise_o,
    input wire logic [ddrsa_pkg::DQ_W-1:0]  dq_fall_o,
    input wire logic                        dq_oe_b_o,
    input wire logic                        rd_valid_o,
    input wire logic                        wr_ready_o,
    input wire logic                        busy_o,
    input wire logic                        cmd_err_o,
    input wire logic [ddrsa_pkg::BANKS-1:0] bank_open_o
);
    import ddrsa_pkg::*;
    logic [2:0] op;
    logic [2:0] bk;
    logic       go;
    assign op = cmd_addr_bus_rise_i[2:0];
    assign bk = cmd_addr_bus_rise_i[9:7];
    assign go = cke_i && !busy_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_act;
        go && op == DDRSA_OP_ACT && !bank_open_o[bk] |=> bank_open_o[$past(bk)];
    endproperty
    a_act: assert property (p_act) else $error("bank not opened");
    property p_pre;
        go && op == DDRSA_OP_PRE |=> !bank_open_o[$past(bk)];
    endproperty
    a_pre: assert property (p_pre) else $error("bank not closed");
    property p_bad;
        go && op > 3'h4 |=> cmd_err_o && bank_open_o == $past(bank_open_o);
    endproperty
    a_bad: assert property (p_bad) else $error("bad op not refused");
    property p_busy;
        cke_i && busy_o && op != DDRSA_OP_NOP |=> cmd_err_o;
    endproperty
    a_busy: assert property (p_busy) else $error("command taken while busy");
    property p_closed;
        go && (op == DDRSA_OP_RD || op == DDRSA_OP_WR) && !bank_open_o[bk] |=> cmd_err_o;
    endproperty
    a_closed: assert property (p_closed) else $error("closed bank accessed");
    property p_wr;
        go && op == DDRSA_OP_WR && bank_open_o[bk] && wr_ready_o |=> busy_o [*4] ##1 !busy_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write frame not four cycles");
    property p_rd;
        go && op == DDRSA_OP_RD && bank_open_o[bk] |-> ##[4:120] rd_valid_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read data missing");
    property p_burst;
        $rose(rd_valid_o) |-> rd_valid_o [*4] ##1 !rd_valid_o;
    endproperty
    a_burst: assert property (p_burst) else $error("read burst not eight beats");
    property p_oe;
        rd_valid_o == !dq_oe_b_o && (rd_valid_o || {dq_rise_o, dq_fall_o} == 16'h0000);
    endproperty
    a_oe: assert property (p_oe) else $error("data pins wrong when idle");
endmodule
bind ddrsa_core ddrsa_core_props ddrsa_core_props_i (.clk_i, .rst_b_i, .cke_i,
    .cmd_addr_bus_rise_i, .dq_rise_o, .dq_fall_o, .dq_oe_b_o, .rd_valid_o, .wr_ready_o,
    .busy_o, .cmd_err_o, .bank_open_o);
`default_nettype wire

// [dv/ddrsa_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// Controller side of command and data pins
// ********
module ddrsa_ctl (
    input  wire logic                   clk_i,
    output logic                        cke_o,
    output logic [ddrsa_pkg::CMD_W-1:0] cmd_rise_o,
    output logic [ddrsa_pkg::CMD_W-1:0] cmd_fall_o,
    output logic [ddrsa_pkg::DQ_W-1:0]  dq_rise_o,
    output logic [ddrsa_pkg::DQ_W-1:0]  dq_fall_o
);
    import ddrsa_pkg::*;
    initial
    begin
        cke_o      = 1'b1;
        cmd_rise_o = 10'h000;
        cmd_fall_o = 10'h000;
        dq_rise_o  = 8'h5A;
        dq_fall_o  = 8'hA5;
    end
    task automatic send(input logic [2:0] op, input logic [2:0] bank,
                        input logic [13:0] row, input logic [9:0] col);
        @(posedge clk_i);
        cmd_rise_o <= {bank, row[13:10], op};
        cmd_fall_o <= (op == DDRSA_OP_ACT) ? row[9:0] : col;
    endtask
    // Fall half of a NOP means nothing, so keep it moving
    task automatic idle();
        @(posedge clk_i);
        cmd_rise_o <= 10'h000;
        cmd_fall_o <= ~cmd_fall_o;
    endtask
    task automatic hold_cke(input logic v);
        @(posedge clk_i);
        cke_o <= v;
    endtask
    task automatic wdata(input logic [63:0] w);
        @(posedge clk_i);
        cmd_rise_o <= 10'h000;
        for (int k = 0; k < 4; k++)
        begin
            dq_rise_o <= w[16*k +: 8];
            dq_fall_o <= w[16*k+8 +: 8];
            @(posedge clk_i);
        end
        dq_rise_o <= ~dq_rise_o;
        dq_fall_o <= ~dq_fall_o;
    endtask
endmodule
`default_nettype wire

// [logic/ddrsa_core.sv]
// Contract
// - Storage is eight independent banks chosen by bank bits of each command.
// - Command, address and bank all arrive on one ten-bit command bus.
// - One command per cycle, bus sampled on rising and falling halves.
// - Data path prefetches 8n; each data line moves two bits per cycle.
// - One core word of 8n bits per access, serialised as eight n-bit beats.
// - Bursts start at selected column and wrap over eight in sequential order.
// - Activate uses its bank and address bits to open that bank's row.
// - Read or write uses its bits to pick bank and starting column.
`timescale 1ns/100ps
`default_nettype none
module ddrsa_core (
    input  wire logic                        clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        cke_i,
    input  wire logic [ddrsa_pkg::CMD_W-1:0] cmd_addr_bus_rise_i,
    input  wire logic [ddrsa_pkg::CMD_W-1:0] cmd_addr_bus_fall_i,
    input  wire logic [ddrsa_pkg::DQ_W-1:0]  dq_rise_i,
    input  wire logic [ddrsa_pkg::DQ_W-1:0]  dq_fall_i,
    output logic [ddrsa_pkg::DQ_W-1:0]       dq_rise_o,
    output logic [ddrsa_pkg::DQ_W-1:0]       dq_fall_o,
    output logic                             dq_oe_b_o,
    output logic                             rd_valid_o,
    output logic                             wr_ready_o,
    output logic                             busy_o,
    output logic                             cmd_err_o,
    output logic [ddrsa_pkg::BANKS-1:0]      bank_open_o
);
    import ddrsa_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_WR_DATA,
        ST_RD_WAIT,
        ST_RD_MEM,
        ST_RD_OUT
    } ddrsa_state_t;

    // ************************************************************
    // Command capture
    // ************************************************************
    ddrsa_cmd_t cmd;

    always_comb
    begin
        cmd.op   = ddrsa_op_t'(cmd_addr_bus_rise_i[CMD_OP_LSB +: CMD_OP_W]);
        cmd.bank = cmd_addr_bus_rise_i[CMD_BANK_LSB +: BANK_W];
        cmd.row  = {cmd_addr_bus_rise_i[CMD_RHI_LSB +: CMD_RHI_W], cmd_addr_bus_fall_i};
        cmd.col  = cmd_addr_bus_fall_i;
    end

    // ************************************************************
    // Bank table
    // ************************************************************
    logic [BANKS-1:0]            open_ff;
    logic [BANKS-1:0][ROW_W-1:0] row_ff;
    logic [BANKS-1:0]            nxt_open;
    logic [BANKS-1:0][ROW_W-1:0] nxt_row;
    logic                        do_act;
    logic                        do_pre;

    always_comb
    begin
        nxt_open = open_ff;
        nxt_row  = row_ff;
        if (do_act)
        begin
            nxt_open[cmd.bank] = 1'b1;
            nxt_row[cmd.bank]  = cmd.row;
        end
        if (do_pre)
        begin
            nxt_open[cmd.bank] = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            open_ff <= OPEN_RST;
            row_ff  <= '0;
        end
        else
        begin
            open_ff <= nxt_open;
            row_ff  <= nxt_row;
        end
    end

    assign bank_open_o = open_ff;

    // ************************************************************
    // Access sequencer
    // ************************************************************
    ddrsa_state_t      state_ff;
    ddrsa_state_t      nxt_state;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [BEAT_W-1:0] start_ff;
    logic [BEAT_W-1:0] nxt_start;
    logic [MEM_AW-1:0] idx_ff;
    logic [MEM_AW-1:0] nxt_idx;
    logic [WORD_W-1:0] asm_ff;
    logic [WORD_W-1:0] nxt_asm;
    logic [DQ_W-1:0]   dq_rise_ff;
    logic [DQ_W-1:0]   dq_fall_ff;
    logic [DQ_W-1:0]   nxt_dq_rise;
    logic [DQ_W-1:0]   nxt_dq_fall;
    logic              drive_ff;
    logic              nxt_drive;
    logic              err_ff;
    logic              nxt_err;
    logic [WORD_W-1:0] rd_data_ff;
    logic [WORD_W-1:0] mem [MEM_WORDS];
    logic [BEAT_W-1:0] beat_r;
    logic [BEAT_W-1:0] beat_f;
    logic              live;
    logic              bank_ok;
    ddrsa_wentry_t     fifo_in;
    ddrsa_wentry_t     fifo_out;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;

    assign live    = cke_i && (cmd.op != DDRSA_OP_NOP);
    assign bank_ok = open_ff[cmd.bank];
    // Sequential wrap inside the eight-beat burst
    assign beat_r  = BEAT_W'(start_ff + {cnt_ff, 1'b0});
    assign beat_f  = BEAT_W'(start_ff + {cnt_ff, 1'b1});

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_start     = start_ff;
        nxt_idx       = idx_ff;
        nxt_asm       = asm_ff;
        nxt_dq_rise   = DQ_IDLE;
        nxt_dq_fall   = DQ_IDLE;
        nxt_drive     = 1'b0;
        nxt_err       = 1'b0;
        do_act        = 1'b0;
        do_pre        = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in.idx   = idx_ff;
        fifo_in.data  = asm_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (live)
                begin
                    nxt_cnt   = '0;
                    nxt_start = cmd.col[BEAT_W-1:0];
                    nxt_idx   = {cmd.bank, row_ff[cmd.bank][MEM_ROW_B-1:0],
                                 cmd.col[BEAT_W +: MEM_COL_B]};
                    case (cmd.op)
                        DDRSA_OP_ACT:
                        begin
                            do_act  = !bank_ok;
                            nxt_err = bank_ok;
                        end
                        DDRSA_OP_PRE: do_pre = 1'b1;
                        DDRSA_OP_RD:
                        begin
                            // Closed bank: access refused
                            nxt_err   = !bank_ok;
                            nxt_state = bank_ok ? ST_RD_WAIT : ST_IDLE;
                        end
                        DDRSA_OP_WR:
                        begin
                            // Refused when closed or the write buffer is full
                            nxt_err   = !bank_ok || !fifo_in_ready;
                            nxt_state = (bank_ok && fifo_in_ready) ? ST_WR_DATA : ST_IDLE;
                        end
                        default: nxt_err = 1'b1;
                    endcase
                end
            end
            ST_WR_DATA:
            begin
                nxt_asm[beat_r*DQ_W +: DQ_W] = dq_rise_i;
                nxt_asm[beat_f*DQ_W +: DQ_W] = dq_fall_i;
                nxt_cnt = CNT_W'(cnt_ff + 1'b1);
                nxt_err = live;
                if (cnt_ff == CNT_LAST)
                begin
                    fifo_in.data  = nxt_asm;
                    fifo_in_valid = 1'b1;
                    nxt_state     = ST_IDLE;
                end
            end
            ST_RD_WAIT:
            begin
                // Older writes must land before the core is read
                nxt_err = live;
                if (!fifo_out_valid)
                begin
                    nxt_state = ST_RD_MEM;
                end
            end
            ST_RD_MEM:
            begin
                nxt_err   = live;
                nxt_state = ST_RD_OUT;
            end
            ST_RD_OUT:
            begin
                nxt_dq_rise = rd_data_ff[beat_r*DQ_W +: DQ_W];
                nxt_dq_fall = rd_data_ff[beat_f*DQ_W +: DQ_W];
                nxt_drive   = 1'b1;
                nxt_cnt     = CNT_W'(cnt_ff + 1'b1);
                nxt_err     = live;
                if (cnt_ff == CNT_LAST)
                begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= '0;
            start_ff   <= '0;
            idx_ff     <= '0;
            asm_ff     <= '0;
            dq_rise_ff <= DQ_IDLE;
            dq_fall_ff <= DQ_IDLE;
            drive_ff   <= 1'b0;
            err_ff     <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            start_ff   <= nxt_start;
            idx_ff     <= nxt_idx;
            asm_ff     <= nxt_asm;
            dq_rise_ff <= nxt_dq_rise;
            dq_fall_ff <= nxt_dq_fall;
            drive_ff   <= nxt_drive;
            err_ff     <= nxt_err;
        end
    end

    assign dq_rise_o  = dq_rise_ff;
    assign dq_fall_o  = dq_fall_ff;
    assign dq_oe_b_o  = !drive_ff;
    assign rd_valid_o = drive_ff;
    assign cmd_err_o  = err_ff;
    assign busy_o     = (state_ff != ST_IDLE);
    assign wr_ready_o = fifo_in_ready;

    // ************************************************************
    // Core array and write buffer
    // ************************************************************
    // Reads never share a cycle with a drain, so one port pair suffices
    assign fifo_out_ready = (state_ff != ST_RD_MEM);

    always_ff @(posedge clk_i)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            mem[fifo_out.idx] <= fifo_out.data;
        end
        rd_data_ff <= mem[idx_ff];
    end

    ddrsa_fifo #(
        .WIDTH ($bits(ddrsa_wentry_t)),
        .DEPTH (FIFO_DEPTH)
    ) ddrsa_fifo_i (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out)
    );

endmodule
`default_nettype wire

// [logic/ddrsa_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Write-data FIFO
// ****************************************************************
module ddrsa_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic [AW-1:0]    nxt_wp;
    logic [AW-1:0]    nxt_rp;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rp_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        nxt_wp  = push ? AW'(wp_ff + 1'b1) : wp_ff;
        nxt_rp  = pop ? AW'(rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop)
        begin
            nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
        end
        else if (pop && !push)
        begin
            nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; only counted entries are ever read
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end

endmodule
`default_nettype wire

// [logic/ddrsa_pkg.sv]
// ****************************************************************
// Shared constants and types
// ****************************************************************
`default_nettype none
package ddrsa_pkg;

    localparam int unsigned CMD_W      = 10;
    localparam int unsigned BANKS      = 8;
    localparam int unsigned BANK_W     = 3;
    localparam int unsigned ROW_W      = 14;
    localparam int unsigned COL_W      = 10;
    localparam int unsigned DQ_W       = 8;
    localparam int unsigned BURST_LEN  = 8;
    localparam int unsigned BEAT_W     = 3;
    localparam int unsigned WORD_W     = DQ_W * BURST_LEN;
    localparam int unsigned CYC_PER_BL = BURST_LEN / 2;
    localparam int unsigned CNT_W      = 2;
    localparam int unsigned FIFO_DEPTH = 16;

    // Field positions on the rising half of the bus
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_OP_W     = 3;
    localparam int unsigned CMD_RHI_LSB  = 3;
    localparam int unsigned CMD_RHI_W    = 4;
    localparam int unsigned CMD_BANK_LSB = 7;

    // Storage kept small: bank, two row bits, two word-column bits
    localparam int unsigned MEM_ROW_B = 2;
    localparam int unsigned MEM_COL_B = 2;
    localparam int unsigned MEM_AW    = BANK_W + MEM_ROW_B + MEM_COL_B;
    localparam int unsigned MEM_WORDS = 1 << MEM_AW;

    localparam logic [BANKS-1:0]           OPEN_RST = 8'h00;
    localparam logic [CNT_W-1:0]           CNT_LAST = 2'h3;
    localparam logic [DQ_W-1:0]            DQ_IDLE  = 8'h00;

    typedef enum logic [CMD_OP_W-1:0] {
        DDRSA_OP_NOP = 3'h0,
        DDRSA_OP_ACT = 3'h1,
        DDRSA_OP_RD  = 3'h2,
        DDRSA_OP_WR  = 3'h3,
        DDRSA_OP_PRE = 3'h4
    } ddrsa_op_t;

    typedef struct packed {
        ddrsa_op_t         op;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
    } ddrsa_cmd_t;

    typedef struct packed {
        logic [MEM_AW-1:0] idx;
        logic [WORD_W-1:0] data;
    } ddrsa_wentry_t;

endpackage
`default_nettype wire
